// [src/switch_ctrl_pkg.sv]
package switch_ctrl_pkg;

	// Core clock
	localparam int CLK_PERIOD_NS = 4;
	localparam int NS_PER_US = 1000;
	localparam int CYCLES_PER_US = NS_PER_US / CLK_PERIOD_NS;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_GC0 = 8'h02;
	localparam logic [7:0] IDX_GC1 = 8'h03;
	localparam logic [11:0] ADDR_GC0 = {2'h0, IDX_GC0, 2'h0};
	localparam logic [11:0] ADDR_GC1 = {2'h0, IDX_GC1, 2'h0};

	// Global control zero fields (bits 7:3 belong elsewhere and read zero here)
	localparam int GC0_LINK_AGE = 0;
	localparam int GC0_CF_DROP = 1;
	localparam int GC0_SHARE = 2;
	localparam logic [7:0] GC0_MASK = 8'h07;
	localparam logic [7:0] GC0_RESET = 8'h04;

	// Global control one fields
	localparam int GC1_BACKOFF = 0;
	localparam int GC1_FAST_AGE = 1;
	localparam int GC1_AGE_EN = 2;
	localparam int GC1_LEN_CHECK = 3;
	localparam int GC1_RX_FC_DIS = 4;
	localparam int GC1_TX_FC_DIS = 5;
	localparam int GC1_RESERVED = 6;
	localparam int GC1_PASS_ALL = 7;
	// Pull defaults of the straps: flow control pin low, aging pin high, back-off pin low
	localparam logic [7:0] GC1_RESET = 8'h04;

	// Frame classification
	localparam logic [15:0] PAUSE_TYPE = 16'h8808;
	localparam logic [47:0] PAUSE_DA = 48'h0180C2000001;
	localparam logic [15:0] LEN_TYPE_LIMIT = 16'h05DC;

	// Aging times
	localparam int NORMAL_AGE_S = 300;
	localparam int US_PER_S = 1000000;
	localparam int NORMAL_AGE_US = NORMAL_AGE_S * US_PER_S;
	localparam int FAST_AGE_US = 800;

	// Strap settle time in cycles after reset release
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	typedef struct packed {
		logic [15:0] typeLen;
		logic [47:0] dstAddr;
		logic [15:0] payloadLen;
		logic flowCtrl;
		logic errored;
	} frame_info_s;

	typedef struct packed {
		logic bufferShared;
		logic [15:0] portBufLimit;
		logic aggressiveBackoff;
		logic [4:0] txPauseEn;
		logic [4:0] rxPauseEn;
	} ctrl_s;

endpackage : switch_ctrl_pkg

// [src/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Pins
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinSync
);

	logic [W-1:0] meta_r;

	initial begin
		if (W < 1) $error("pin_sync: width must be at least one");
	end

	// The first stage feeds only the second
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= '0;
			pinSync <= '0;
		end else begin
			meta_r <= pinIn;
			pinSync <= meta_r;
		end
	end

endmodule : pin_sync

// [src/age_timer.sv]
`timescale 1ns/1ps
module age_timer #(
	parameter int NPORTS = 5,
	parameter int NORMAL_US = switch_ctrl_pkg::NORMAL_AGE_US,
	parameter int FAST_US = switch_ctrl_pkg::FAST_AGE_US
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Configuration
	input wire logic ageEnable,
	input wire logic fastAge,
	input wire logic linkChangeAge,
	// Synchronised link state
	input wire logic [NPORTS-1:0] linkUp,
	// Aging engine strobes
	output logic ageTick,
	output logic flushAll
);

	localparam logic [7:0] US_LAST = 8'(switch_ctrl_pkg::CYCLES_PER_US - 1);
	// The link-change cycle must finish strictly under the fast period
	localparam logic [31:0] LINK_LAST = 32'(FAST_US - 2);
	localparam logic [31:0] FAST_LAST = 32'(FAST_US - 1);
	localparam logic [31:0] NORMAL_LAST = 32'(NORMAL_US - 1);

	logic [7:0] usCnt_r;
	logic [31:0] ageCnt_r;
	logic [NPORTS-1:0] linkPrev_r;
	logic fastPending_r;
	logic usTick;
	logic linkDrop;
	logic [31:0] periodLast;
	logic periodDone;

	initial begin
		if (FAST_US < 2 || NORMAL_US <= FAST_US || NPORTS < 1)
			$error("age_timer: unusable period or port count");
	end

	assign usTick = (usCnt_r == US_LAST);
	assign linkDrop = |(linkPrev_r & ~linkUp);
	assign periodLast = fastPending_r ? LINK_LAST : (fastAge ? FAST_LAST : NORMAL_LAST);
	assign periodDone = usTick && (ageCnt_r >= periodLast);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			usCnt_r <= 8'h00;
		end else if (usTick) begin
			usCnt_r <= 8'h00;
		end else begin
			usCnt_r <= usCnt_r + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			linkPrev_r <= '0;
		end else begin
			linkPrev_r <= linkUp;
		end
	end

	// Aging off clears the count; with link-change aging on, a link drop restarts it on the fast cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ageCnt_r <= 32'h0000_0000;
			ageTick <= 1'b0;
		end else begin
			ageTick <= ageEnable && periodDone && !(linkChangeAge && linkDrop);
			if (!ageEnable || (linkChangeAge && linkDrop) || periodDone) begin
				ageCnt_r <= 32'h0000_0000;
			end else if (usTick) begin
				ageCnt_r <= ageCnt_r + 32'h0000_0001;
			end
		end
	end

	// A new drop in the closing cycle keeps the fast cycle pending
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fastPending_r <= 1'b0;
		end else if (linkChangeAge && linkDrop) begin
			fastPending_r <= 1'b1;
		end else if (ageEnable && periodDone) begin
			fastPending_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			flushAll <= 1'b0;
		end else begin
			flushAll <= linkChangeAge && linkDrop;
		end
	end

	a_link_flush: assert property (@(posedge ref_clk) disable iff (!reset_n)
		linkChangeAge && linkDrop |=> flushAll && fastPending_r)
		else $error("link drop did not flush the table");

	a_age_disabled: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!ageEnable ##1 !ageEnable |-> !ageTick && ageCnt_r == 32'h0000_0000)
		else $error("aging ran while disabled");

endmodule : age_timer

// [src/switch_global_control_regs.sv]
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module switch_global_control_regs #(
	parameter int NPORTS = 5,
	parameter int POOL_BLOCKS = 320,
	parameter int NORMAL_US = switch_ctrl_pkg::NORMAL_AGE_US,
	parameter int FAST_US = switch_ctrl_pkg::FAST_AGE_US
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Strap and link pins
	input wire logic flowControlStrapPin,
	input wire logic backoffStrapPin,
	input wire logic agingStrapPin,
	input wire logic [NPORTS-1:0] linkUp,
	// Autonegotiation result per port
	input wire logic [NPORTS-1:0] anTxPause,
	input wire logic [NPORTS-1:0] anRxPause,
	// Received frame descriptor
	input wire logic frameValid,
	input wire switch_ctrl_pkg::frame_info_s frameInfo,
	input wire logic snifferEn,
	output logic frameDrop,
	output logic frameForward,
	// Switch core controls
	output switch_ctrl_pkg::ctrl_s ctrl,
	output logic lengthCheckEn,
	output logic ageTick,
	output logic ageFlushAll
);

	localparam logic [15:0] FULL_LIMIT = 16'(POOL_BLOCKS);
	localparam logic [15:0] PORT_LIMIT = 16'(POOL_BLOCKS / 5);

	logic [7:0] gc0_r;
	logic [7:0] gc1_r;
	logic [1:0] settle_r;
	logic strapDone_r;
	logic strapLoad;
	logic [2:0] strapSync;
	logic [NPORTS-1:0] linkSync;
	logic setupPhase;
	logic accessWrite;
	logic hitGc0;
	logic hitGc1;
	logic passAll;
	logic ctlDrop;
	logic lenMismatch;
	logic dropNxt;

	initial begin
		if (NPORTS != 5 || POOL_BLOCKS < 5 || POOL_BLOCKS > 65535)
			$error("switch_global_control_regs: unsupported ports or pool size");
	end

	pin_sync #(
		.W(3)
	) u_strap_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pinIn({agingStrapPin, backoffStrapPin, flowControlStrapPin}),
		.pinSync(strapSync)
	);

	pin_sync #(
		.W(NPORTS)
	) u_link_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pinIn(linkUp),
		.pinSync(linkSync)
	);

	// Straps are sampled once, after the synchronisers have filled
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			settle_r <= 2'h0;
			strapDone_r <= 1'b0;
		end else if (!strapDone_r) begin
			settle_r <= settle_r + 2'h1;
			strapDone_r <= (settle_r == switch_ctrl_pkg::STRAP_SETTLE);
		end
	end

	assign strapLoad = !strapDone_r && (settle_r == switch_ctrl_pkg::STRAP_SETTLE);

	// APB decode; the slave never inserts wait states
	assign pready = 1'b1;
	assign setupPhase = psel && !penable;
	assign accessWrite = psel && penable && pwrite && pstrb[0];
	assign hitGc0 = (paddr == switch_ctrl_pkg::ADDR_GC0);
	assign hitGc1 = (paddr == switch_ctrl_pkg::ADDR_GC1);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setupPhase) begin
			if (hitGc0) begin
				prdata <= {24'h00_0000, gc0_r};
				pslverr <= 1'b0;
			end else if (hitGc1) begin
				prdata <= {24'h00_0000, gc1_r};
				pslverr <= 1'b0;
			end else begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			gc0_r <= switch_ctrl_pkg::GC0_RESET;
		end else if (accessWrite && hitGc0) begin
			gc0_r <= pwdata[7:0] & switch_ctrl_pkg::GC0_MASK;
		end
	end

	// A software write in the load cycle wins over the strap value
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			gc1_r <= switch_ctrl_pkg::GC1_RESET;
		end else if (accessWrite && hitGc1) begin
			gc1_r <= pwdata[7:0];
		end else if (strapLoad) begin
			gc1_r[switch_ctrl_pkg::GC1_TX_FC_DIS] <= strapSync[0];
			gc1_r[switch_ctrl_pkg::GC1_RX_FC_DIS] <= strapSync[0];
			gc1_r[switch_ctrl_pkg::GC1_BACKOFF] <= strapSync[1];
			gc1_r[switch_ctrl_pkg::GC1_AGE_EN] <= strapSync[2];
		end
	end

	// Frame filter
	assign passAll = gc1_r[switch_ctrl_pkg::GC1_PASS_ALL] && snifferEn;
	assign ctlDrop = gc0_r[switch_ctrl_pkg::GC0_CF_DROP]
		? (frameInfo.typeLen == switch_ctrl_pkg::PAUSE_TYPE
			|| frameInfo.dstAddr == switch_ctrl_pkg::PAUSE_DA)
		: frameInfo.flowCtrl;
	assign lenMismatch = gc1_r[switch_ctrl_pkg::GC1_LEN_CHECK]
		&& frameInfo.typeLen < switch_ctrl_pkg::LEN_TYPE_LIMIT
		&& frameInfo.typeLen != frameInfo.payloadLen;
	assign dropNxt = !passAll && (frameInfo.errored || ctlDrop || lenMismatch);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			frameDrop <= 1'b0;
			frameForward <= 1'b0;
		end else begin
			frameDrop <= frameValid && dropNxt;
			frameForward <= frameValid && !dropNxt;
		end
	end

	// Core controls, registered
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= '0;
			lengthCheckEn <= 1'b0;
		end else begin
			ctrl.bufferShared <= gc0_r[switch_ctrl_pkg::GC0_SHARE];
			ctrl.portBufLimit <= gc0_r[switch_ctrl_pkg::GC0_SHARE] ? FULL_LIMIT : PORT_LIMIT;
			ctrl.aggressiveBackoff <= gc1_r[switch_ctrl_pkg::GC1_BACKOFF];
			ctrl.txPauseEn <= gc1_r[switch_ctrl_pkg::GC1_TX_FC_DIS] ? '0 : anTxPause;
			ctrl.rxPauseEn <= gc1_r[switch_ctrl_pkg::GC1_RX_FC_DIS] ? '0 : anRxPause;
			lengthCheckEn <= gc1_r[switch_ctrl_pkg::GC1_LEN_CHECK];
		end
	end

	age_timer #(
		.NPORTS(NPORTS),
		.NORMAL_US(NORMAL_US),
		.FAST_US(FAST_US)
	) u_age_timer (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.ageEnable(gc1_r[switch_ctrl_pkg::GC1_AGE_EN]),
		.fastAge(gc1_r[switch_ctrl_pkg::GC1_FAST_AGE]),
		.linkChangeAge(gc0_r[switch_ctrl_pkg::GC0_LINK_AGE]),
		.linkUp(linkSync),
		.ageTick(ageTick),
		.flushAll(ageFlushAll)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_share_limit: assert property (
		accessWrite && hitGc0
		|-> ##2 ctrl.portBufLimit == ($past(pwdata[2], 2) ? FULL_LIMIT : PORT_LIMIT))
		else $error("buffer limit does not follow share mode");

	a_cf_type_drop: assert property (
		frameValid && gc0_r[1] && !passAll && frameInfo.typeLen == 16'h8808 |=> frameDrop)
		else $error("pause type frame not dropped");

	a_cf_da_drop: assert property (
		frameValid && gc0_r[1] && !passAll && frameInfo.dstAddr == 48'h0180C2000001
		|=> frameDrop && !frameForward)
		else $error("pause address frame not dropped");

	a_flow_only_drop: assert property (
		frameValid && !gc0_r[1] && !passAll && !frameInfo.errored && !lenMismatch
		|=> frameDrop == $past(frameInfo.flowCtrl))
		else $error("drop does not follow flow control qualification");

	a_pass_all: assert property (
		frameValid && gc1_r[7] && snifferEn |=> frameForward && !frameDrop)
		else $error("pass-all frame was dropped");

	a_tx_pause: assert property (
		reset_n |=> ctrl.txPauseEn == ($past(gc1_r[5]) ? 5'h00 : $past(anTxPause)))
		else $error("transmit pause does not follow disable bit");

	a_rx_pause: assert property (
		reset_n |=> ctrl.rxPauseEn == ($past(gc1_r[4]) ? 5'h00 : $past(anRxPause)))
		else $error("receive pause does not follow disable bit");

	a_strap_load: assert property (
		strapLoad && !(accessWrite && hitGc1)
		|=> gc1_r[5] == $past(strapSync[0]) && gc1_r[4] == $past(strapSync[0])
			&& gc1_r[2] == $past(strapSync[2]) && gc1_r[0] == $past(strapSync[1]))
		else $error("strap values not loaded");

	a_len_check: assert property (
		frameValid && !passAll && gc1_r[3] && frameInfo.typeLen < 16'h05DC
		&& frameInfo.typeLen != frameInfo.payloadLen |=> frameDrop)
		else $error("length mismatch frame not dropped");

	a_backoff_out: assert property (
		accessWrite && hitGc1 |-> ##2 ctrl.aggressiveBackoff == $past(pwdata[0], 2))
		else $error("back-off output does not follow register");

	a_frame_exclusive: assert property (
		frameValid |=> frameDrop != frameForward)
		else $error("frame verdict is not exactly one of drop and forward");

	a_frame_idle: assert property (
		!frameValid |=> !frameDrop && !frameForward)
		else $error("frame verdict without a frame");

	a_sniff_needed: assert property (
		frameValid && !snifferEn && frameInfo.errored |=> frameDrop)
		else $error("errored frame passed without sniffer mode");

	a_cf_other_fwd: assert property (
		frameValid && gc0_r[switch_ctrl_pkg::GC0_CF_DROP] && !passAll && !frameInfo.errored
		&& !lenMismatch && frameInfo.typeLen != switch_ctrl_pkg::PAUSE_TYPE
		&& frameInfo.dstAddr != switch_ctrl_pkg::PAUSE_DA |=> frameForward)
		else $error("ordinary frame dropped in drop mode");

	a_len_long_pass: assert property (
		frameValid && !passAll && !frameInfo.errored && !ctlDrop
		&& frameInfo.typeLen >= switch_ctrl_pkg::LEN_TYPE_LIMIT |=> frameForward)
		else $error("type field frame dropped by length check");

	a_len_mirror: assert property (
		reset_n |=> lengthCheckEn == $past(gc1_r[switch_ctrl_pkg::GC1_LEN_CHECK]))
		else $error("length check output does not follow register");

	a_share_flag: assert property (
		reset_n |=> ctrl.bufferShared == $past(gc0_r[switch_ctrl_pkg::GC0_SHARE]))
		else $error("share flag does not follow register");

	a_gc1_write: assert property (
		accessWrite && hitGc1 |=> gc1_r == $past(pwdata[7:0]))
		else $error("second register write not stored");

	a_gc1_strobe: assert property (
		psel && penable && pwrite && !pstrb[0] && !strapLoad
		|=> $stable(gc1_r) && $stable(gc0_r))
		else $error("register changed on a masked write");

	a_read_gc0: assert property (
		setupPhase && hitGc0 |=> prdata == {24'h00_0000, $past(gc0_r)})
		else $error("first register read data wrong");

	a_read_gc1: assert property (
		setupPhase && hitGc1 |=> prdata == {24'h00_0000, $past(gc1_r)})
		else $error("second register read data wrong");

endmodule : switch_global_control_regs

// [bench/switch_global_control_regs_test.sv]
`timescale 1ns/1ps
module switch_global_control_regs_test;
	// Short aging periods keep the run brief; expectations scale with them
	localparam int NUS = 20;
	localparam int FUS = 10;
	localparam int CPU = switch_ctrl_pkg::CYCLES_PER_US;
	localparam logic [11:0] A0 = switch_ctrl_pkg::ADDR_GC0;
	localparam logic [11:0] A1 = switch_ctrl_pkg::ADDR_GC1;
	localparam logic [47:0] PDA = switch_ctrl_pkg::PAUSE_DA;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [4:0] linkUp = 5'h1F;
	logic [4:0] anTxPause = 5'h1F;
	logic [4:0] anRxPause = 5'h15;
	logic frameValid = 1'b0;
	switch_ctrl_pkg::frame_info_s frameInfo = '0;
	logic snifferEn = 1'b0;
	logic strapFc = 1'b1;
	logic strapBo = 1'b1;
	logic strapAge = 1'b0;
	logic frameDrop, frameForward, lengthCheckEn, ageTick, ageFlushAll;
	switch_ctrl_pkg::ctrl_s ctrl;
	int nMismatch = 0;
	int samplesChecked = 0;
	logic [31:0] rd;
	logic err;
	int gap;
	int n;

	switch_global_control_regs #(.NORMAL_US(NUS), .FAST_US(FUS)) uut (
		.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flowControlStrapPin(strapFc), .backoffStrapPin(strapBo), .agingStrapPin(strapAge),
		.linkUp(linkUp), .anTxPause(anTxPause), .anRxPause(anRxPause),
		.frameValid(frameValid), .frameInfo(frameInfo), .snifferEn(snifferEn),
		.frameDrop(frameDrop), .frameForward(frameForward), .ctrl(ctrl),
		.lengthCheckEn(lengthCheckEn), .ageTick(ageTick), .ageFlushAll(ageFlushAll)
	);

	always #2 ref_clk = ~ref_clk;

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		// Only the watchdog ends a slave that never answers
		while (pready !== 1'b1) @(posedge ref_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000, 4'hF);
		check(nm, rd, e);
		#1;
	endtask : rdchk

	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h000000, d}, 4'hF);
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : wr

	task frm(input logic [15:0] t, input logic [47:0] da, input logic [15:0] pl,
		input logic fc, input logic er, input logic dr);
		@(posedge ref_clk);
		frameValid <= 1'b1;
		frameInfo <= '{t, da, pl, fc, er};
		@(posedge ref_clk);
		frameValid <= 1'b0;
		#1;
		check("frameDrop", frameDrop, dr);
		check("frameForward", frameForward, !dr);
	endtask : frm

	// Counts cycles up to the next aging pass, bounded so a dead timer cannot hang
	task tick(output int c);
		c = 0;
		forever begin
			@(posedge ref_clk);
			#1;
			c++;
			if (ageTick === 1'b1 || c >= 12000) break;
		end
	endtask : tick

	task print_verdict;
		$display("Counts: %0d compared, %0d mismatched", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (60000) @(posedge ref_clk);
		nMismatch++;
		print_verdict();
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rdchk("gc0", A0, 32'h00000004);
		rdchk("gc1", A1, 32'h00000031);
		check("shared", ctrl.bufferShared, 1'b1);
		check("limit", ctrl.portBufLimit, 16'h0140);
		check("backoff", ctrl.aggressiveBackoff, 1'b1);
		check("txEn", ctrl.txPauseEn, 5'h00);
		check("rxEn", ctrl.rxPauseEn, 5'h00);
		$display("Test reset done");
		apb(1'b1, A1, 32'hFFFFFF10, 4'hF);
		apb(1'b1, A1, 32'h000000BF, 4'hE);
		rdchk("gc1", A1, 32'h00000010);
		check("txEn", ctrl.txPauseEn, 5'h1F);
		check("rxEn", ctrl.rxPauseEn, 5'h00);
		check("backoff", ctrl.aggressiveBackoff, 1'b0);
		wr(A1, 8'h20);
		check("txEn", ctrl.txPauseEn, 5'h00);
		check("rxEn", ctrl.rxPauseEn, 5'h15);
		$display("Test flow control done");
		wr(A0, 8'hFF);
		rdchk("gc0", A0, 32'h00000007);
		wr(A0, 8'h00);
		check("shared", ctrl.bufferShared, 1'b0);
		check("limit", ctrl.portBufLimit, 16'h0040);
		apb(1'b0, 12'h010, 32'h00000000, 4'hF);
		check("unmappedErr", err, 1'b1);
		check("unmappedData", rd, 32'h00000000);
		$display("Test buffer share done");
		wr(A0, 8'h02);
		wr(A1, 8'h08);
		check("lenCheck", lengthCheckEn, 1'b1);
		frm(16'h8808, 48'h000000000000, 16'h0000, 1'b0, 1'b0, 1'b1);
		frm(16'h0800, PDA, 16'h0000, 1'b0, 1'b0, 1'b1);
		frm(16'h0800, 48'h0180C2000002, 16'h0000, 1'b1, 1'b0, 1'b0);
		frm(16'h0064, 48'h000000000001, 16'h0064, 1'b0, 1'b0, 1'b0);
		frm(16'h0064, 48'h000000000001, 16'h0050, 1'b0, 1'b0, 1'b1);
		frm(16'h05DC, 48'h000000000001, 16'h0000, 1'b0, 1'b0, 1'b0);
		wr(A0, 8'h00);
		wr(A1, 8'h00);
		frm(16'h8808, PDA, 16'h0000, 1'b0, 1'b0, 1'b0);
		frm(16'h0800, 48'h000000000001, 16'h0000, 1'b1, 1'b0, 1'b1);
		frm(16'h0064, 48'h000000000001, 16'h0050, 1'b0, 1'b0, 1'b0);
		frm(16'h0800, 48'h000000000001, 16'h0000, 1'b0, 1'b1, 1'b1);
		wr(A1, 8'h80);
		@(posedge ref_clk);
		snifferEn <= 1'b1;
		frm(16'h0800, 48'h000000000001, 16'h0000, 1'b0, 1'b1, 1'b0);
		@(posedge ref_clk);
		snifferEn <= 1'b0;
		frm(16'h0800, 48'h000000000001, 16'h0000, 1'b0, 1'b1, 1'b1);
		$display("Test frame filter done");
		wr(A1, 8'h04);
		tick(gap);
		tick(gap);
		check("normalGap", gap, NUS * CPU);
		wr(A1, 8'h06);
		tick(gap);
		tick(gap);
		check("fastGap", gap, FUS * CPU);
		wr(A1, 8'h04);
		wr(A0, 8'h01);
		tick(gap);
		@(posedge ref_clk);
		linkUp <= 5'h1B;
		n = 0;
		while (ageFlushAll !== 1'b1 && n < 8) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check("flushSeen", n < 8, 1'b1);
		tick(gap);
		check("linkFastGap", gap < FUS * CPU && gap > (FUS - 2) * CPU, 1'b1);
		tick(gap);
		check("resumeGap", gap, NUS * CPU);
		wr(A1, 8'h00);
		n = 0;
		repeat (NUS * CPU + 1000) begin
			@(posedge ref_clk);
			#1;
			if (ageTick === 1'b1) n++;
		end
		check("ticksOff", n, 0);
		$display("Test aging done");
		// Second reset with every strap at its pull default
		@(posedge ref_clk);
		reset_n <= 1'b0;
		strapFc <= 1'b0;
		strapBo <= 1'b0;
		strapAge <= 1'b1;
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rdchk("gc1Pulled", A1, 32'h00000004);
		check("backoffPulled", ctrl.aggressiveBackoff, 1'b0);
		check("txEnPulled", ctrl.txPauseEn, 5'h1F);
		check("rxEnPulled", ctrl.rxPauseEn, 5'h15);
		tick(gap);
		tick(gap);
		check("strapAgeGap", gap, NUS * CPU);
		$display("Test strap defaults done");
		print_verdict();
	end
endmodule : switch_global_control_regs_test
